//--- hdl/adc_conversion_sequencer.sv
// converter setup registers and conversion sequencing for a power monitor
// assumes the serial host logic presents one-cycle register strobes and the
// front end follows fe_select while fe_converting is high
`default_nettype none

module adc_conversion_sequencer
    import conv_seq_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // converter front end
    output logic             fe_converting,
    output logic      [1:0]  fe_select,
    output logic             sample_end,
    // result handling
    output logic             result_load,
    output logic      [1:0]  result_chan,
    output logic             set_done,
    output logic             powered_down
);

    seq_state_t        state_q, state_d;
    logic [15:0]       setup_q, setup_d;
    logic [15:0]       cfg_q, cfg_d;
    logic [15:0]       rdata_q, rdata_d;
    logic              start_q, start_d;
    logic [1:0]        chan_q, chan_d;
    logic              phase_q, phase_d;
    logic [SAMP_W-1:0] samp_q, samp_d;
    logic              conv_q, conv_d;
    logic [1:0]        sel_q, sel_d;
    logic              send_q, send_d;
    logic              load_q, load_d;
    logic [1:0]        rchan_q, rchan_d;
    logic              sdone_q, sdone_d;
    logic              pd_q, pd_d;

    logic              tmr_load;
    logic [TIME_W-1:0] tmr_us;
    logic              tmr_done;
    logic              launch;
    logic [1:0]        launch_ch;
    logic              restart;
    logic [3:0]        mode;
    logic              mode_valid;
    logic              mode_cont;
    logic [2:0]        chan_en;
    logic [SAMP_W-1:0] samp_total;

    // first enabled channel at or after a position in the set
    function automatic logic [1:0] pick_chan(input logic [1:0] from,
                                             input logic [2:0] en);
        pick_chan = CH_NONE;
        for (int i = 2; i >= 0; i--) begin
            if (i >= int'(from) && en[i]) begin
                pick_chan = 2'(i);
            end
        end
    endfunction : pick_chan

    // first interval of one sample on a channel
    function automatic logic [TIME_W-1:0] chan_time(input logic [1:0]  ch,
                                                    input logic [15:0] s);
        logic [12:0] t;
        t = conv_time_us(s[BUS_CT_HI:BUS_CT_LO]);
        if (ch == CH_TEMP) begin
            t = conv_time_us(s[TEMP_CT_HI:TEMP_CT_LO]);
        end else if (ch == CH_CURR) begin
            t = conv_time_us(s[SHUNT_CT_HI:SHUNT_CT_LO]);
        end
        chan_time = TIME_W'(t);
    endfunction : chan_time

    conv_timer #(
        .TICK (TICK_CYCLES_P),
        .TW   (TIME_W)
    ) u_timer (
        .clk     (clk),
        .nrst    (nrst),
        .load    (tmr_load),
        .load_us (tmr_us),
        .done    (tmr_done)
    );

    // mode decode; reserved codes behave as shutdown
    always_comb begin
        mode       = setup_q[MODE_HI:MODE_LO];
        mode_cont  = mode[3];
        mode_valid = mode[2] || (mode[2:0] == 3'h1);
        chan_en    = {mode[1], mode[2], mode[0]};
        samp_total = avg_samples(setup_q[AVG_HI:AVG_LO]);
    end

    always_comb begin
        state_d   = state_q;
        setup_d   = setup_q;
        cfg_d     = cfg_q;
        rdata_d   = rdata_q;
        start_d   = start_q;
        chan_d    = chan_q;
        phase_d   = phase_q;
        samp_d    = samp_q;
        conv_d    = conv_q;
        sel_d     = sel_q;
        send_d    = 1'b0;
        load_d    = 1'b0;
        rchan_d   = rchan_q;
        sdone_d   = 1'b0;
        pd_d      = !mode_valid;
        tmr_load  = 1'b0;
        tmr_us    = '0;
        launch    = 1'b0;
        launch_ch = CH_NONE;
        restart   = 1'b0;

        if (reg_wr) begin
            if (reg_addr == ADDR_CONFIG) begin
                if (reg_wdata[SOFT_RST_BIT]) begin
                    // self-clearing soft reset, never stored
                    setup_d = SETUP_RESET;
                    cfg_d   = CONFIG_RESET;
                    restart = 1'b1;
                end else begin
                    cfg_d = reg_wdata & DELAY_MASK;
                end
            end else if (reg_addr == ADDR_SETUP) begin
                setup_d = reg_wdata;
                restart = 1'b1;
            end
        end

        if (reg_rd) begin
            if (reg_addr == ADDR_CONFIG) begin
                rdata_d = cfg_q | CONFIG_RO_ONES;
            end else if (reg_addr == ADDR_SETUP) begin
                rdata_d = setup_q;
            end else begin
                rdata_d = 16'h0000;
            end
        end

        case (state_q)
            ST_IDLE: begin
                conv_d = 1'b0;
                if (start_q) begin
                    start_d = 1'b0;
                    if (mode_valid) begin
                        state_d  = ST_DELAY;
                        tmr_load = 1'b1;
                        tmr_us   = TIME_W'(TIME_W'(cfg_q[DELAY_HI:DELAY_LO])
                                   * TIME_W'(DELAY_STEP_US));
                    end
                end
            end
            ST_DELAY: begin
                if (tmr_done) begin
                    launch    = 1'b1;
                    launch_ch = pick_chan(CH_BUS, chan_en);
                end
            end
            ST_CONV: begin
                if (tmr_done) begin
                    if (chan_q == CH_CURR && !phase_q) begin
                        // second half of a current sample
                        phase_d  = 1'b1;
                        sel_d    = SEL_TEMP;
                        tmr_load = 1'b1;
                        tmr_us   = chan_time(CH_TEMP, setup_q);
                    end else begin
                        send_d = 1'b1;
                        if (samp_q == samp_total - SAMP_W'(1)) begin
                            load_d    = 1'b1;
                            rchan_d   = chan_q;
                            launch_ch = pick_chan(chan_q + 2'h1, chan_en);
                            if (chan_q == CH_CURR) begin
                                launch_ch = CH_NONE;
                            end
                            if (launch_ch != CH_NONE) begin
                                launch = 1'b1;
                            end else begin
                                sdone_d = 1'b1;
                                if (mode_cont) begin
                                    launch    = 1'b1;
                                    launch_ch = pick_chan(CH_BUS, chan_en);
                                end else begin
                                    state_d = ST_IDLE;
                                    conv_d  = 1'b0;
                                end
                            end
                        end else begin
                            samp_d   = samp_q + SAMP_W'(1);
                            phase_d  = 1'b0;
                            sel_d    = (chan_q == CH_CURR) ? SEL_SHUNT
                                     : (chan_q == CH_TEMP) ? SEL_TEMP
                                     : SEL_BUS;
                            tmr_load = 1'b1;
                            tmr_us   = chan_time(chan_q, setup_q);
                        end
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase

        if (launch) begin
            if (launch_ch == CH_NONE) begin
                state_d = ST_IDLE;
                conv_d  = 1'b0;
            end else begin
                state_d  = ST_CONV;
                chan_d   = launch_ch;
                phase_d  = 1'b0;
                samp_d   = '0;
                conv_d   = 1'b1;
                sel_d    = (launch_ch == CH_CURR) ? SEL_SHUNT
                         : (launch_ch == CH_TEMP) ? SEL_TEMP
                         : SEL_BUS;
                tmr_load = 1'b1;
                tmr_us   = chan_time(launch_ch, setup_q);
            end
        end

        // a new mode aborts any set in flight and starts over
        if (restart) begin
            state_d = ST_IDLE;
            start_d = 1'b1;
            conv_d  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            setup_q <= SETUP_RESET;
            cfg_q   <= CONFIG_RESET;
            rdata_q <= 16'h0000;
            start_q <= 1'b1;
            chan_q  <= CH_BUS;
            phase_q <= 1'b0;
            samp_q  <= '0;
            conv_q  <= 1'b0;
            sel_q   <= SEL_BUS;
            send_q  <= 1'b0;
            load_q  <= 1'b0;
            rchan_q <= CH_BUS;
            sdone_q <= 1'b0;
            pd_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            setup_q <= setup_d;
            cfg_q   <= cfg_d;
            rdata_q <= rdata_d;
            start_q <= start_d;
            chan_q  <= chan_d;
            phase_q <= phase_d;
            samp_q  <= samp_d;
            conv_q  <= conv_d;
            sel_q   <= sel_d;
            send_q  <= send_d;
            load_q  <= load_d;
            rchan_q <= rchan_d;
            sdone_q <= sdone_d;
            pd_q    <= pd_d;
        end
    end

    assign reg_rdata     = rdata_q;
    assign fe_converting = conv_q;
    assign fe_select     = sel_q;
    assign sample_end    = send_q;
    assign result_load   = load_q;
    assign result_chan   = rchan_q;
    assign set_done      = sdone_q;
    assign powered_down  = pd_q;

endmodule : adc_conversion_sequencer

`default_nettype wire

//--- hdl/conv_timer.sv
// microsecond down-counter used for start delay and conversion intervals
// assumes load is a one-cycle pulse from logic on the same clock
`default_nettype none

module conv_timer #(
    parameter int TICK = 25,
    parameter int TW   = 19
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // control
    input  wire logic          load,
    input  wire logic [TW-1:0] load_us,
    // status
    output logic               done
);
    localparam int DIV_W = (TICK > 1) ? $clog2(TICK) : 1;

    logic [DIV_W-1:0] div_q, div_d;
    logic [TW-1:0]    cnt_q, cnt_d;
    logic             busy_q, busy_d;
    logic             done_q, done_d;

    always_comb begin
        div_d  = div_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (load) begin
            // divider restarts so every interval is whole microseconds
            cnt_d  = load_us;
            div_d  = '0;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                done_d = 1'b1;
                busy_d = 1'b0;
            end else if (div_q == DIV_W'(TICK - 1)) begin
                div_d = '0;
                cnt_d = cnt_q - TW'(1);
            end else begin
                div_d = div_q + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;

endmodule : conv_timer

`default_nettype wire

//--- include/conv_seq_pkg.sv
// constants, field layout and timing tables for the conversion sequencer
// assumes a single 25 MHz clock shared by every user of the package
`default_nettype none

package conv_seq_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS = 40;
    localparam int US_NS         = 1000;
    localparam int TICK_CYCLES   = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_STEP_MS = 2;
    localparam int DELAY_STEP_US = DELAY_STEP_MS * 1000;
    localparam int TIME_W        = 19;
    localparam int SAMP_W        = 11;

    // register map
    localparam logic [5:0]  ADDR_CONFIG    = 6'h00;
    localparam logic [5:0]  ADDR_SETUP     = 6'h01;
    localparam logic [15:0] SETUP_RESET    = 16'hfb68;
    localparam logic [15:0] CONFIG_RESET   = 16'h0000;
    localparam logic [15:0] CONFIG_RO_ONES = 16'h0010;
    localparam logic [15:0] DELAY_MASK     = 16'h3fc0;

    // field positions
    localparam int SOFT_RST_BIT = 15;
    localparam int DELAY_HI     = 13;
    localparam int DELAY_LO     = 6;
    localparam int MODE_HI      = 15;
    localparam int MODE_LO      = 12;
    localparam int BUS_CT_HI    = 11;
    localparam int BUS_CT_LO    = 9;
    localparam int SHUNT_CT_HI  = 8;
    localparam int SHUNT_CT_LO  = 6;
    localparam int TEMP_CT_HI   = 5;
    localparam int TEMP_CT_LO   = 3;
    localparam int AVG_HI       = 2;
    localparam int AVG_LO       = 0;

    // channel order of a conversion set
    localparam logic [1:0] CH_BUS  = 2'h0;
    localparam logic [1:0] CH_TEMP = 2'h1;
    localparam logic [1:0] CH_CURR = 2'h2;
    localparam logic [1:0] CH_NONE = 2'h3;

    // front end input select
    localparam logic [1:0] SEL_BUS   = 2'h0;
    localparam logic [1:0] SEL_SHUNT = 2'h1;
    localparam logic [1:0] SEL_TEMP  = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV  = 2'b10
    } seq_state_t;

    function automatic logic [12:0] conv_time_us(input logic [2:0] code);
        case (code)
            3'h0:    conv_time_us = 13'h0032;
            3'h1:    conv_time_us = 13'h0054;
            3'h2:    conv_time_us = 13'h0096;
            3'h3:    conv_time_us = 13'h0118;
            3'h4:    conv_time_us = 13'h021c;
            3'h5:    conv_time_us = 13'h041c;
            3'h6:    conv_time_us = 13'h081a;
            default: conv_time_us = 13'h1018;
        endcase
    endfunction : conv_time_us

    function automatic logic [SAMP_W-1:0] avg_samples(input logic [2:0] code);
        case (code)
            3'h0:    avg_samples = 11'h001;
            3'h1:    avg_samples = 11'h004;
            3'h2:    avg_samples = 11'h010;
            3'h3:    avg_samples = 11'h040;
            3'h4:    avg_samples = 11'h080;
            3'h5:    avg_samples = 11'h100;
            3'h6:    avg_samples = 11'h200;
            default: avg_samples = 11'h400;
        endcase
    endfunction : avg_samples

endpackage : conv_seq_pkg

`default_nettype wire

//--- tb/adc_conversion_sequencer_test.sv
// self-checking bench for the conversion sequencer
// assumes one microsecond per clock (TICK_CYCLES_P of 1) to keep runs short
`default_nettype none

module adc_conversion_sequencer_test
    import conv_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, clr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [5:0]  reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
    logic        fe_converting, sample_end, result_load, set_done, pdn;
    logic [1:0]  fe_select, result_chan;
    logic [7:0]  seq;
    logic [3:0]  nres;
    logic [10:0] nmin, nmax;
    logic [3:0][15:0] len;
    int fails = 0;
    int checks = 0;
    int us_tab[8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    int avg_tab[5] = '{1, 4, 16, 64, 128};
    logic [2:0] tmode[5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [7:0] tseq[5] = '{8'h00, 8'h01, 8'h01, 8'h06, 8'h06};
    int tn[5] = '{1, 1, 2, 2, 3};

    always #20 clk = ~clk;

    adc_conversion_sequencer #(.TICK_CYCLES_P(1)) DUT (
        .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .fe_converting(fe_converting), .fe_select(fe_select),
        .sample_end(sample_end), .result_load(result_load),
        .result_chan(result_chan), .set_done(set_done), .powered_down(pdn));
    fe_model u_fe (
        .clk(clk), .nrst(nrst), .clr(clr), .fe_converting(fe_converting),
        .fe_select(fe_select), .sample_end(sample_end),
        .result_load(result_load), .result_chan(result_chan), .seq(seq),
        .nres(nres), .nmin(nmin), .nmax(nmax), .len(len));

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input logic [15:0] g);
        checks++;
        if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1)) begin
            fails++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        rv = reg_rdata;
    endtask : rd

    task automatic run(input logic [15:0] v);
        wr(ADDR_SETUP, v);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
    endtask : run

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (set_done !== 1'b1 && n < lim);
        chk("set_done", 16'h0001, {15'h0000, set_done});
        repeat (2) @(negedge clk);
    endtask : wait_done

    task automatic start_wait(input int lo, input int hi);
        int n;
        n = 0;
        while (fe_converting !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk_rng("start wait", lo, hi, n[15:0]);
    endtask : start_wait

    task automatic t_reset;
        logic [3:0] off[3] = '{4'h0, 4'h8, 4'h2};
        rd(ADDR_SETUP);
        chk("setup", SETUP_RESET, rv);
        rd(ADDR_CONFIG);
        chk("config", 16'h0010, rv);
        rd(6'h05);
        chk("unmapped", 16'h0000, rv);
        foreach (off[i]) begin
            wr(ADDR_SETUP, {off[i], 12'h0abc});
            repeat (4) @(negedge clk);
            chk("powered_down", 16'h0001, {15'h0000, pdn});
            chk("fe_converting", 16'h0000, {15'h0000, fe_converting});
            rd(ADDR_SETUP);
            chk("setup", {off[i], 12'h0abc}, rv);
        end
    endtask : t_reset

    task automatic t_sets(input logic cont);
        foreach (tmode[i]) begin
            run({cont, tmode[i], 12'h000});
            wait_done(3000);
            if (cont) begin
                run({cont, tmode[i], 12'h000});
                wait_done(3000);
                clr = 1'b1;
                @(negedge clk);
                clr = 1'b0;
                wait_done(3000);
            end
            chk("results", tn[i], {12'h000, nres});
            chk("order", tseq[i], seq & 8'((1 << (2 * tn[i])) - 1));
            repeat (cont ? 6 : 20) @(negedge clk);
            chk("running", cont, {15'h0000, fe_converting});
        end
    endtask : t_sets

    task automatic t_times;
        for (int c = 0; c < 8; c++) begin
            run({4'h1, c[2:0], 9'h000});
            wait_done(9000);
            chk_rng("bus time", us_tab[c] - 2, us_tab[c] + 4, len[SEL_BUS]);
        end
        run({4'h4, 6'h00, 3'h2, 3'h0});
        wait_done(3000);
        chk_rng("temp time", 148, 154, len[SEL_TEMP]);
        run({4'h6, 3'h0, 3'h1, 3'h3, 3'h0});
        wait_done(3000);
        chk_rng("shunt time", 82, 88, len[SEL_SHUNT]);
        chk_rng("curr temp", 278, 284, len[SEL_TEMP]);
    endtask : t_times

    task automatic t_avg;
        for (int a = 0; a < 5; a++) begin
            run({4'h5, 9'h000, a[2:0]});
            wait_done(avg_tab[a] * 130 + 200);
            chk("results", 16'h0002, {12'h000, nres});
            chk("min samples", avg_tab[a], {5'h00, nmin});
            chk("max samples", avg_tab[a], {5'h00, nmax});
        end
    endtask : t_avg

    task automatic t_delay;
        wr(ADDR_CONFIG, 16'h0040);
        rd(ADDR_CONFIG);
        chk("config", 16'h0050, rv);
        wr(ADDR_SETUP, 16'h1000);
        start_wait(2000, 2010);
        // soft reset must also clear the start delay
        wr(ADDR_CONFIG, 16'h8000);
        rd(ADDR_SETUP);
        chk("setup", SETUP_RESET, rv);
        rd(ADDR_CONFIG);
        chk("config", 16'h0010, rv);
        wr(ADDR_SETUP, 16'h1000);
        start_wait(0, 8);
    endtask : t_delay

    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        $display("MISMATCH watchdog expected done seen timeout");
        finish_test();
    end

    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_sets(1'b0);
        t_sets(1'b1);
        t_times();
        t_avg();
        t_delay();
        finish_test();
    end
endmodule : adc_conversion_sequencer_test

`default_nettype wire

//--- tb/conv_seq_checker_assertions.sv
// port checker for the conversion sequencer
// assumes binding to adc_conversion_sequencer, one clock, sync reset
`default_nettype none

module conv_seq_checker
    import conv_seq_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [5:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // front end and results
    input wire logic        fe_converting,
    input wire logic [1:0]  fe_select,
    input wire logic        sample_end,
    input wire logic        result_load,
    input wire logic [1:0]  result_chan,
    input wire logic        set_done,
    input wire logic        powered_down
);
    localparam int LO = 50 * TICK_CYCLES_P - 3;
    localparam int HI = 8240 * TICK_CYCLES_P + 8;
    logic        set_wr;
    logic        soft_wr;
    logic [3:0]  mode_q, mode_d;
    logic [2:0]  avg_q, avg_d;
    logic [10:0] scnt_q, scnt_d, avg_n;
    logic [19:0] cnt_q, cnt_d;
    // a write after a set ends may legally restart conversions
    logic        seen_q, seen_d;

    assign set_wr  = reg_wr && reg_addr == ADDR_SETUP;
    assign soft_wr = reg_wr && reg_addr == ADDR_CONFIG && reg_wdata[15];
    assign avg_n   = (avg_q < 3'h3) ? 11'h001 << {avg_q, 1'b0}
                                    : 11'h001 << ({1'b0, avg_q} + 4'h3);

    always_comb begin
        mode_d = mode_q;
        avg_d  = avg_q;
        seen_d = set_wr || soft_wr || (seen_q && !set_done);
        scnt_d = result_load ? 11'h000 : scnt_q + {10'h000, sample_end};
        cnt_d  = (sample_end || !fe_converting) ? 20'h0_0000 : cnt_q + 20'h1;
        if (set_wr) begin
            mode_d = reg_wdata[MODE_HI:MODE_LO];
            avg_d  = reg_wdata[AVG_HI:AVG_LO];
            scnt_d = 11'h000;
        end
        if (soft_wr) begin
            mode_d = 4'hf;
            avg_d  = 3'h0;
            scnt_d = 11'h000;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_q <= 4'hf;
            avg_q  <= 3'h0;
            scnt_q <= 11'h000;
            cnt_q  <= 20'h0_0000;
            seen_q <= 1'b0;
        end else begin
            seen_q <= seen_d;
            mode_q <= mode_d;
            avg_q  <= avg_d;
            scnt_q <= scnt_d;
            cnt_q  <= cnt_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_setup_wr;
        set_wr;
    endsequence
    sequence s_quiet8;
        (!fe_converting || seen_q) [*8];
    endsequence

    AST_SHUTDOWN: assert property (
        s_setup_wr ##0 reg_wdata[14:12] == 3'h0 |-> ##[1:3] powered_down)
        else $error("shutdown mode not entered");
    AST_STANDBY: assert property (
        powered_down |-> !fe_converting)
        else $error("converting while powered down");
    AST_TRIG_ON: assert property (
        s_setup_wr ##0 reg_wdata[15:12] inside {4'h1, [4'h4:4'h7]}
        |-> ##[1:3] !powered_down)
        else $error("triggered mode left powered down");
    AST_TRIG_IDLE: assert property (
        set_done && !mode_q[3] && !set_wr |=> s_quiet8)
        else $error("triggered set did not stop");
    AST_CONT_NEXT: assert property (
        set_done && mode_q[3] && !set_wr |-> ##[1:4] fe_converting)
        else $error("continuous set did not restart");
    AST_START_GAP: assert property (
        s_setup_wr |=> !fe_converting [*2])
        else $error("conversion began without start delay");
    AST_AVG_LOAD: assert property (
        result_load |-> scnt_q == avg_n - 11'h001)
        else $error("result after wrong sample count");
    AST_LOAD_AFTER_RUN: assert property (
        result_load |-> sample_end)
        else $error("result load without final sample");
    AST_SET_END: assert property (
        set_done |-> result_load)
        else $error("set end without result");
    AST_CURR_HALVES: assert property (
        fe_converting && $past(fe_select) == SEL_SHUNT
        && fe_select != SEL_SHUNT && !$past(reg_wr) |-> fe_select == SEL_TEMP)
        else $error("shunt half not followed by temperature half");
    AST_SAMPLE_TIME: assert property (
        sample_end |-> cnt_q inside {[LO:HI]})
        else $error("sample interval out of range");
endmodule : conv_seq_checker

bind adc_conversion_sequencer conv_seq_checker #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
) u_chk (
    .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fe_converting(fe_converting), .fe_select(fe_select),
    .sample_end(sample_end), .result_load(result_load),
    .result_chan(result_chan), .set_done(set_done),
    .powered_down(powered_down)
);

`default_nettype wire

//--- tb/fe_model.sv
// front end model: times each input interval and logs result channels
// assumes the sequencer's one clock; it drives nothing back
`default_nettype none

module fe_model (
    // clock and control
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              clr,
    // sequencer side
    input  wire logic              fe_converting,
    input  wire logic [1:0]        fe_select,
    input  wire logic              sample_end,
    input  wire logic              result_load,
    input  wire logic [1:0]        result_chan,
    // observations
    output logic      [7:0]        seq,
    output logic      [3:0]        nres,
    output logic      [10:0]       nmin,
    output logic      [10:0]       nmax,
    output logic      [3:0][15:0]  len
);
    logic [1:0]  sel_q;
    logic        rl_q;
    logic [15:0] cnt;
    logic [10:0] nsamp;

    always_ff @(posedge clk) begin
        sel_q <= fe_select;
        rl_q  <= result_load;
        if (sample_end || (fe_converting && fe_select != sel_q)) begin
            len[sel_q] <= cnt;
            cnt        <= {15'h0000, fe_converting};
        end else begin
            cnt <= fe_converting ? cnt + 16'h0001 : 16'h0000;
        end
        if (sample_end) begin
            nsamp <= nsamp + 11'h001;
        end
        // result logged one cycle late, once nsamp has counted the final sample
        if (rl_q) begin
            seq   <= {seq[5:0], result_chan};
            nres  <= nres + 4'h1;
            nmin  <= (nsamp < nmin) ? nsamp : nmin;
            nmax  <= (nsamp > nmax) ? nsamp : nmax;
            nsamp <= 11'h000;
        end
        if (!nrst || clr) begin
            seq   <= 8'h00;
            nres  <= 4'h0;
            nmin  <= 11'h7ff;
            nmax  <= 11'h000;
            nsamp <= 11'h000;
        end
    end
endmodule : fe_model

`default_nettype wire
